// ==== verilog/csdf_pkg.sv ====
/*
 * csdf_pkg: field layout, codes, limits and struct types of the card specific data
 * register bank. Assumes a single 20 MHz clock domain and no bus fabric.
 */
package csdf_pkg;

    // register geometry
    localparam int unsigned CARD_W = 128;

    // field positions (low bit of each field)
    localparam int unsigned POS_STRUCT    = 126;
    localparam int unsigned POS_ACCESS    = 112;
    localparam int unsigned POS_CLKACC    = 104;
    localparam int unsigned POS_SPEED     = 96;
    localparam int unsigned POS_CLASS     = 84;
    localparam int unsigned POS_RBL       = 80;
    localparam int unsigned POS_RPART     = 79;
    localparam int unsigned POS_WMIS      = 78;
    localparam int unsigned POS_RMIS      = 77;
    localparam int unsigned POS_DRV       = 76;
    localparam int unsigned POS_DEVSIZE   = 62;
    localparam int unsigned POS_RCURLO    = 59;
    localparam int unsigned POS_RCURHI    = 56;
    localparam int unsigned POS_WCURLO    = 53;
    localparam int unsigned POS_WCURHI    = 50;
    localparam int unsigned POS_MULT      = 47;
    localparam int unsigned POS_ERBLK     = 46;
    localparam int unsigned POS_SECTOR    = 39;
    localparam int unsigned POS_WPGRP     = 32;
    localparam int unsigned POS_WPEN      = 31;
    localparam int unsigned POS_R2W       = 26;
    localparam int unsigned POS_WBL       = 22;
    localparam int unsigned POS_WPART     = 21;
    localparam int unsigned POS_FMTGRP    = 15;
    localparam int unsigned POS_COPY      = 14;
    localparam int unsigned POS_PERM      = 13;
    localparam int unsigned POS_TEMP      = 12;
    localparam int unsigned POS_FMT       = 10;
    localparam int unsigned POS_CRC       = 1;

    // transfer rate codes
    localparam logic [7:0] SPEED_DEFAULT = 8'h32;
    localparam logic [7:0] SPEED_HIGH    = 8'h5A;

    // block length exponent limits
    localparam logic [3:0] BL_MIN = 4'h9;
    localparam logic [3:0] BL_MAX = 4'hB;
    localparam logic [3:0] BL_2G  = 4'hA;

    // highest legal program speed code
    localparam logic [2:0] R2W_MAX = 3'h5;

    // largest user capacity in bytes, two to the 31st
    localparam logic [39:0] CAP_LIMIT = 40'h00_8000_0000;

    // programmable low byte layout
    typedef struct packed {
        logic       fmt_grp;
        logic       copy;
        logic       perm;
        logic       temp;
        logic [1:0] fmt;
        logic [1:0] rsvd;
        logic [6:0] crc;
    } csdf_prog_t;

    // program request carrier
    typedef struct packed {
        logic       valid;
        csdf_prog_t data;
    } csdf_wr_t;

    // derived status carrier
    typedef struct packed {
        logic wr_blocked;
        logic group_protect_ok;
        logic fields_legal;
    } csdf_stat_t;

    // module state
    typedef struct packed {
        csdf_prog_t prog;
        logic       high_speed;
        logic       prog_err;
    } csdf_state_t;

endpackage

// ==== verilog/csdf_bank.sv ====
/*
 * csdf_bank: the card specific data register. Presents the 128-bit word,
 * takes program commands for the writable low byte and mode changes.
 * Assumes the command layer decodes commands, checks framing and feeds
 * single-cycle strobes; the host recomputes the checksum it writes.
 */
//
// Contract
// - access-time byte: unit 2:0, mantissa 6:3
// - clocked access factor counts 100-cycle units
// - transfer-rate byte: unit 2:0, mantissa 6:3
// - rate 032h default, 05Ah high speed
// - class bit n set when class supported
// - read block exponent only 9 to 11
// - write exponent equals read exponent, 512 ok
// - partial write flag selects 512 or byte
// - misalignment flags allow boundary crossing
// - driver stage flag implies driver register
// - capacity from size, multiplier, block exponent
// - capacity at most 2G, 1024 block
// - current fields three-bit supply codes
// - erase flag zero erases whole sectors
// - erase flag one erases 512 blocks
// - sector field is blocks minus one
// - group field is sectors minus one
// - program speed codes 0 to 5 legal
// - copy flag programmable only once
// - protect flags block writes and erases
// - format codes valid only in group 0; code flags group 1 only with a nonzero code
`timescale 1ns/10ps

module csdf_bank
    import csdf_pkg::*;
#(
    parameter logic [1:0]  STRUCT_VER    = 2'h0,
    parameter logic [7:0]  ACCESS_CODE   = 8'h0E,
    parameter logic [7:0]  CLK_ACC_CODE  = 8'h00,
    parameter logic [11:0] CLASS_SET     = 12'h5B5,
    parameter logic [3:0]  READ_BL_EXP   = 4'h9,
    parameter logic        WRITE_PART    = 1'b0,
    parameter logic        WRITE_MIS     = 1'b0,
    parameter logic        READ_MIS      = 1'b0,
    parameter logic        DRIVER_STAGE  = 1'b0,
    parameter logic [11:0] DEV_SIZE      = 12'h7D0,
    parameter logic [2:0]  SIZE_MULT     = 3'h3,
    parameter logic [2:0]  RCUR_LO       = 3'h5,
    parameter logic [2:0]  RCUR_HI       = 3'h5,
    parameter logic [2:0]  WCUR_LO       = 3'h5,
    parameter logic [2:0]  WCUR_HI       = 3'h5,
    parameter logic        ERASE_BLK     = 1'b1,
    parameter logic [6:0]  SECTOR_BLKS   = 7'h1F,
    parameter logic [6:0]  GROUP_SECT    = 7'h00,
    parameter logic        GROUP_EN      = 1'b1,
    parameter logic [2:0]  R2W_CODE      = 3'h2,
    parameter logic [15:0] PROG_RESET    = 16'h0000 // low byte at power up
)(
    input  wire logic                    clock,
    input  wire logic                    rst_n,
    input  wire csdf_pkg::csdf_wr_t      prog_wr,       // program command strobe
    input  wire logic                    speed_high,    // switch to high speed
    input  wire logic                    speed_default, // switch back to default
    input  wire logic                    card_reset,    // reset command seen
    output logic [csdf_pkg::CARD_W-1:0]  card_specific_data,
    output logic                         prog_rejected, // last program refused
    output csdf_pkg::csdf_stat_t         status
);
    import csdf_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state
    csdf_state_t state_q;  // all flops
    csdf_state_t state_d;  // next value
    logic        illegal;  // program breaks a one-time bit, the copy freeze or the perm lock

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        state_d = state_q;
        // one-time bits may only move while still at reset value
        illegal = (state_q.prog.copy    & ~prog_wr.data.copy)
                | (state_q.prog.perm    & ~prog_wr.data.perm)
                | (state_q.prog.copy    & (prog_wr.data.fmt_grp != state_q.prog.fmt_grp))
                | (state_q.prog.copy    & (prog_wr.data.fmt != state_q.prog.fmt))
                | state_q.prog.perm; // permanent lock freezes bank
        // mode: reset or back-to-default wins over a high-speed request
        if (card_reset || speed_default)
        begin
            state_d.high_speed = 1'b0;
        end
        else if (speed_high)
        begin
            state_d.high_speed = 1'b1;
        end
        // program command: the checksum comes from the host as is
        if (prog_wr.valid)
        begin
            if (illegal)
            begin
                state_d.prog_err = 1'b1;
            end
            else
            begin
                state_d.prog     = prog_wr.data;
                state_d.prog_err = 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            // bit 0 is fixed high, so only bits 15:1 of the reset word are kept
            state_q <= '{prog: PROG_RESET[15:1], high_speed: 1'b0, prog_err: 1'b0};
        end
        else
        begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // word assembly
    always_comb
    begin
        card_specific_data = '0;
        card_specific_data[POS_STRUCT +: 2]  = STRUCT_VER;
        card_specific_data[POS_ACCESS +: 8]  = {1'b0, ACCESS_CODE[6:0]};
        card_specific_data[POS_CLKACC +: 8]  = CLK_ACC_CODE;
        card_specific_data[POS_SPEED +: 8]   = state_q.high_speed ? SPEED_HIGH
                                                                  : SPEED_DEFAULT;
        card_specific_data[POS_CLASS +: 12]  = CLASS_SET;
        card_specific_data[POS_RBL +: 4]     = READ_BL_EXP;
        card_specific_data[POS_RPART]        = 1'b1;
        card_specific_data[POS_WMIS]         = WRITE_MIS;
        card_specific_data[POS_RMIS]         = READ_MIS;
        card_specific_data[POS_DRV]          = DRIVER_STAGE;
        card_specific_data[POS_DEVSIZE +: 12] = DEV_SIZE;
        card_specific_data[POS_RCURLO +: 3]  = RCUR_LO;
        card_specific_data[POS_RCURHI +: 3]  = RCUR_HI;
        card_specific_data[POS_WCURLO +: 3]  = WCUR_LO;
        card_specific_data[POS_WCURHI +: 3]  = WCUR_HI;
        card_specific_data[POS_MULT +: 3]    = SIZE_MULT;
        card_specific_data[POS_ERBLK]        = ERASE_BLK;
        card_specific_data[POS_SECTOR +: 7]  = SECTOR_BLKS;
        card_specific_data[POS_WPGRP +: 7]   = GROUP_SECT;
        card_specific_data[POS_WPEN]         = GROUP_EN;
        card_specific_data[POS_R2W +: 3]     = R2W_CODE;
        card_specific_data[POS_WBL +: 4]     = READ_BL_EXP;
        card_specific_data[POS_WPART]        = WRITE_PART;
        card_specific_data[15:0]             = {state_q.prog, 1'b1};
    end

    ////////////////////////////////////////////////////////////////////////
    // capacity
    // (size + 1) blocks of two to (mult + 2), each two to exp bytes
    // widest case is 13 bits shifted by 24, so 40 bits never overflow
    logic [12:0] block_base;      // device size plus one
    logic [4:0]  cap_shift;       // total power of two
    logic [39:0] capacity_bytes;  // user capacity in bytes
    logic        over_cap;        // capacity coding breaks the cap

    assign block_base     = {1'h0, DEV_SIZE} + 13'h0001;
    assign cap_shift      = {2'h0, SIZE_MULT} + 5'h02 + {1'h0, READ_BL_EXP};
    assign capacity_bytes = {27'h000_0000, block_base} << cap_shift;
    // a full 2G card must use the 1024-byte block, not a larger one
    assign over_cap = (capacity_bytes > CAP_LIMIT)
                    || ((capacity_bytes == CAP_LIMIT) && (READ_BL_EXP != BL_2G));

    ////////////////////////////////////////////////////////////////////////
    // status
    assign prog_rejected = state_q.prog_err;
    assign status.wr_blocked       = state_q.prog.perm | state_q.prog.temp;
    assign status.group_protect_ok = GROUP_EN;
    // static legality plus the live format code
    assign status.fields_legal = (READ_BL_EXP >= BL_MIN) && (READ_BL_EXP <= BL_MAX)
                               && (R2W_CODE <= R2W_MAX)
                               && !over_cap
                               && !(state_q.prog.fmt_grp && state_q.prog.fmt != 2'h0);

    ////////////////////////////////////////////////////////////////////////
    // checks
    speed_mode_a: assert property (@(posedge clock) disable iff (!rst_n)
        (card_reset || speed_default) |=> card_specific_data[POS_SPEED +: 8] == SPEED_DEFAULT)
        else $error("rate did not return to default");
    speed_high_a: assert property (@(posedge clock) disable iff (!rst_n)
        (speed_high && !card_reset && !speed_default)
        |=> card_specific_data[POS_SPEED +: 8] == SPEED_HIGH)
        else $error("rate not high after switch");
    copy_once_a: assert property (@(posedge clock) disable iff (!rst_n)
        $past(card_specific_data[POS_COPY]) |-> card_specific_data[POS_COPY])
        else $error("copy flag cleared");
    perm_lock_a: assert property (@(posedge clock) disable iff (!rst_n)
        card_specific_data[POS_PERM] |=> $stable(card_specific_data[15:1]))
        else $error("locked bank changed");
    blk_equal_a: assert property (@(posedge clock) disable iff (!rst_n)
        card_specific_data[POS_WBL +: 4] == card_specific_data[POS_RBL +: 4])
        else $error("block exponents differ");
    prog_take_a: assert property (@(posedge clock) disable iff (!rst_n)
        (prog_wr.valid && !illegal) |=> card_specific_data[15:1] == $past(prog_wr.data))
        else $error("program not taken");
    reject_a: assert property (@(posedge clock) disable iff (!rst_n)
        (prog_wr.valid && illegal) |=> prog_rejected && $stable(card_specific_data[15:1]))
        else $error("illegal program accepted");
    block_out_a: assert property (@(posedge clock) disable iff (!rst_n)
        status.wr_blocked == (card_specific_data[POS_PERM] | card_specific_data[POS_TEMP]))
        else $error("protect status wrong");
    end_bit_a: assert property (@(posedge clock) disable iff (!rst_n)
        card_specific_data[0] && !card_specific_data[POS_ACCESS + 7])
        else $error("fixed bits wrong");

    ////////////////////////////////////////////////////////////////////////
    // fixed encodings
    // mantissa code zero is reserved
    access_mant_a: assert property (@(posedge clock) disable iff (!rst_n)
        card_specific_data[POS_ACCESS + 3 +: 4] != 4'h0)
        else $error("access mantissa reserved");

    // rate units above 100 Mbit/s are reserved
    rate_unit_a: assert property (@(posedge clock) disable iff (!rst_n)
        card_specific_data[POS_SPEED +: 3] <= 3'h3)
        else $error("rate unit reserved");

    // top bit reserved and mantissa never zero
    rate_rsvd_a: assert property (@(posedge clock) disable iff (!rst_n)
        !card_specific_data[POS_SPEED + 7] && (card_specific_data[POS_SPEED + 3 +: 4] != 4'h0))
        else $error("rate byte reserved bits");

    // only the two documented rate codes ever show
    rate_codes_a: assert property (@(posedge clock) disable iff (!rst_n)
        (card_specific_data[POS_SPEED +: 8] == SPEED_DEFAULT)
        || (card_specific_data[POS_SPEED +: 8] == SPEED_HIGH))
        else $error("rate code unknown");

    // no mode strobe, no rate change
    rate_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
        !(speed_high || speed_default || card_reset)
        |=> $stable(card_specific_data[POS_SPEED +: 8]))
        else $error("rate moved without strobe");

    // read exponent inside 512 to 2048 bytes
    read_exp_a: assert property (@(posedge clock) disable iff (!rst_n)
        (card_specific_data[POS_RBL +: 4] >= BL_MIN) && (card_specific_data[POS_RBL +: 4] <= BL_MAX))
        else $error("read exponent reserved");

    // the write block is never below 512 bytes
    write_exp_a: assert property (@(posedge clock) disable iff (!rst_n)
        card_specific_data[POS_WBL +: 4] >= BL_MIN)
        else $error("write exponent too small");

    // partial reads are always permitted
    read_part_a: assert property (@(posedge clock) disable iff (!rst_n)
        card_specific_data[POS_RPART])
        else $error("partial read flag low");

    // coded capacity stays within 2G bytes
    cap_limit_a: assert property (@(posedge clock) disable iff (!rst_n)
        capacity_bytes <= CAP_LIMIT)
        else $error("capacity above limit");

    // a full-size card reports the 1024-byte block
    cap_block_a: assert property (@(posedge clock) disable iff (!rst_n)
        (capacity_bytes == CAP_LIMIT) |-> (card_specific_data[POS_RBL +: 4] == BL_2G))
        else $error("full card block wrong");

    // program speed codes 6 and 7 are reserved
    prog_speed_a: assert property (@(posedge clock) disable iff (!rst_n)
        card_specific_data[POS_R2W +: 3] <= R2W_MAX)
        else $error("program speed reserved");

    ////////////////////////////////////////////////////////////////////////
    // programming
    // an accepted program clears the refusal flag
    rej_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
        (prog_wr.valid && !illegal) |=> !prog_rejected)
        else $error("refusal flag stuck");

    // once copied, the format group is frozen
    copy_grp_a: assert property (@(posedge clock) disable iff (!rst_n)
        (prog_wr.valid && card_specific_data[POS_COPY]
         && (prog_wr.data.fmt_grp != card_specific_data[POS_FMTGRP])) |=> prog_rejected)
        else $error("group changed after copy");

    // permanent protection never comes off
    perm_sticky_a: assert property (@(posedge clock) disable iff (!rst_n)
        $past(card_specific_data[POS_PERM]) |-> card_specific_data[POS_PERM])
        else $error("permanent protect cleared");

    // reserved format codes of group one are flagged
    fmt_legal_a: assert property (@(posedge clock) disable iff (!rst_n)
        (card_specific_data[POS_FMTGRP] && (card_specific_data[POS_FMT +: 2] != 2'h0))
        |-> !status.fields_legal)
        else $error("reserved format not flagged");

    // without a program strobe the writable byte holds
    idle_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
        !prog_wr.valid |=> $stable(card_specific_data[15:1]))
        else $error("byte moved without program");

endmodule

// ==== verification/csdf_host.sv ====
/*
 * csdf_host: host side model that programs the writable low byte.
 * Assumes the bank samples prog_wr on rising edges of clock.
 */
`timescale 1ns/10ps
module csdf_host
(
    input  wire logic                       clock,
    input  wire logic [csdf_pkg::CARD_W-1:0] card_specific_data,
    output csdf_pkg::csdf_wr_t              prog_wr
);
    import csdf_pkg::*;

    // idle strobe from time zero
    initial prog_wr = '0;

    ////////////////////////////////////////////////////////////////////////
    // checksum over bits 127:8, polynomial x^7 + x^3 + 1
    function automatic logic [6:0] crc7(input logic [119:0] d);
        logic [6:0] c;
        logic       fb;
        c = '0;
        for (int i = 119; i >= 0; i--)
        begin
            fb = d[i] ^ c[6];
            c  = {c[5:0], 1'h0} ^ (fb ? 7'h09 : 7'h00);
        end
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // one-cycle strobe; f is {group, copy, perm, temp, format}
    task automatic send_prog(input logic [5:0] f);
        logic [127:0] w;
        w        = card_specific_data;
        w[15:10] = f;
        @(negedge clock);
        prog_wr <= {1'h1, f, w[9:8], crc7(w[127:8])};
        @(negedge clock);
        // released data is garbage, not the last value
        prog_wr <= {1'h0, ~prog_wr.data};
    endtask
endmodule

// ==== verification/tb.sv ====
/*
 * tb: self-checking bench for the card specific data bank.
 * Assumes csdf_host drives program strobes; speed strobes come from here.
 */
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; \
    $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module tb;
    import csdf_pkg::*;

    logic             clock, rst_n;           // clock and reset
    logic             speed_high, speed_default, card_reset; // mode strobes
    logic             prog_rejected;          // refusal flag
    csdf_wr_t         prog_wr;                // from host model
    csdf_stat_t       status;                 // derived status
    logic [CARD_W-1:0] card_specific_data;    // register word
    int               fail_count, check_count;

    csdf_bank uut (.clock(clock), .rst_n(rst_n), .prog_wr(prog_wr),
        .speed_high(speed_high), .speed_default(speed_default),
        .card_reset(card_reset), .card_specific_data(card_specific_data),
        .prog_rejected(prog_rejected), .status(status));
    csdf_host host_model (.clock(clock), .card_specific_data(card_specific_data),
        .prog_wr(prog_wr));

    // 50 ns period
    initial
    begin
        clock = 1'h0;
        forever #25 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task summarize;
        if (fail_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // mode strobe for one cycle, then read the speed byte
    task mode(input logic h, input logic d, input logic r, input logic [7:0] e);
        @(negedge clock);
        {speed_high, speed_default, card_reset} = {h, d, r};
        @(negedge clock);
        {speed_high, speed_default, card_reset} = 3'h0;
        `CHK(card_specific_data[103:96], e)
    endtask

    // one program command with expected outcome
    task prog(input logic [5:0] f, input logic rej, input logic [5:0] e, input logic blk);
        host_model.send_prog(f);
        `CHK(prog_rejected, rej)
        `CHK(card_specific_data[15:10], e)
        `CHK(status.wr_blocked, blk)
        `CHK(card_specific_data[7:1], host_model.crc7(card_specific_data[127:8]))
    endtask

    ////////////////////////////////////////////////////////////////////////
    // values straight after reset
    task t_reset;
        `CHK(card_specific_data[103:96], SPEED_DEFAULT)
        `CHK(card_specific_data[119], 1'h0)
        `CHK(card_specific_data[25:22], card_specific_data[83:80])
        `CHK(card_specific_data[79], 1'h1)
        `CHK(card_specific_data[13:12], 2'h0)
        `CHK(prog_rejected, 1'h0)
        `CHK(status.fields_legal, 1'h1)
        `CHK(status.group_protect_ok, 1'h1)
    endtask

    // speed byte switching, the reset command winning a same-cycle request
    task t_speed;
        mode(1'h1, 1'h0, 1'h0, SPEED_HIGH);
        mode(1'h0, 1'h1, 1'h0, SPEED_DEFAULT);
        mode(1'h1, 1'h0, 1'h0, SPEED_HIGH);
        mode(1'h0, 1'h0, 1'h1, SPEED_DEFAULT);
        mode(1'h1, 1'h0, 1'h1, SPEED_DEFAULT);
    endtask

    // protect, copy and format programming, refusals included
    task t_prog;
        prog(6'h04, 1'h0, 6'h04, 1'h1);
        prog(6'h00, 1'h0, 6'h00, 1'h0);
        prog(6'h03, 1'h0, 6'h03, 1'h0);
        prog(6'h23, 1'h0, 6'h23, 1'h0);
        `CHK(status.fields_legal, 1'h0)
        prog(6'h13, 1'h0, 6'h13, 1'h0);
        prog(6'h03, 1'h1, 6'h13, 1'h0);
        prog(6'h33, 1'h1, 6'h13, 1'h0);
        prog(6'h1B, 1'h0, 6'h1B, 1'h1);
        prog(6'h1F, 1'h1, 6'h1B, 1'h1);
    endtask

    // hang guard
    initial
    begin
        repeat (2000) @(posedge clock);
        fail_count++;
        summarize;
    end

    // main sequence
    initial
    begin
        {rst_n, speed_high, speed_default, card_reset} = 4'h0;
        repeat (20) @(negedge clock);
        rst_n = 1'h1;
        @(negedge clock);
        t_reset;
        t_speed;
        t_prog;
        summarize;
    end
endmodule
